// file: rtl/cbwd_pkg.sv
package cbwd_pkg;

    // ------------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // ------------------------------------------------------------------
    localparam logic [7:0] CBWD_IDX_LAT_COUNT = 8'h1b;
    localparam logic [7:0] CBWD_IDX_MEM0_LO   = 8'h1c;
    localparam logic [7:0] CBWD_IDX_MEM0_HI   = 8'h20;
    localparam logic [7:0] CBWD_IDX_MEM1_LO   = 8'h24;
    localparam logic [7:0] CBWD_IDX_MEM1_HI   = 8'h28;
    localparam logic [7:0] CBWD_IDX_IO0_LO    = 8'h2c;
    localparam logic [7:0] CBWD_IDX_IO0_HI    = 8'h30;
    localparam logic [7:0] CBWD_IDX_IO1_LO    = 8'h34;
    localparam logic [7:0] CBWD_IDX_IO1_HI    = 8'h38;
    localparam logic [7:0] CBWD_IDX_IRQ_LINE  = 8'h3c;
    localparam logic [7:0] CBWD_IDX_BRIDGE    = 8'h3e;
    localparam logic [7:0] CBWD_IDX_LAT_STAT  = 8'h40;

    localparam int CBWD_ADDR_W = 12;

    // ------------------------------------------------------------------
    // Writable bit masks and reset values.
    // ------------------------------------------------------------------
    localparam logic [31:0] CBWD_MEM_WMASK    = 32'hfffff000;
    localparam logic [31:0] CBWD_IO_WMASK     = 32'h0000fffc;
    localparam logic [31:0] CBWD_BYTE_WMASK   = 32'h000000ff;
    localparam logic [31:0] CBWD_BRIDGE_WMASK = 32'h00000300;
    localparam logic [31:0] CBWD_MEM_LOW_ONES = 32'h00000fff;
    localparam logic [31:0] CBWD_IO_LOW_ONES  = 32'h00000003;
    localparam logic [31:0] CBWD_IO_PAGE_MASK = 32'hffff0000;
    localparam logic [7:0]  CBWD_LAT_RESET    = 8'h00;
    localparam logic [7:0]  CBWD_IRQ_RESET    = 8'hff;
    localparam logic [31:0] CBWD_WIN_RESET    = 32'h00000000;
    localparam int          CBWD_PF0_BIT      = 8;
    localparam int          CBWD_PF1_BIT      = 9;
    localparam logic [1:0]  CBWD_PF_RESET     = 2'b11;

    localparam logic [1:0]  CBWD_RESP_OKAY    = 2'b00;
    localparam logic [1:0]  CBWD_RESP_SLVERR  = 2'b10;

    localparam int CBWD_BUF_DEPTH = 2;
    // Result word: fwd, hit, window index, is_io, prefetchable.
    localparam int CBWD_RES_W     = 5;

endpackage : cbwd_pkg

// file: rtl/cbwd_top.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// Shift buffer: the head always sits in a flip-flop.
// ----------------------------------------------------------------------
module cbwd_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 2
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] slot [DEPTH];
    logic [DEPTH:0]   fill;
    logic             push;
    logic             pop;
    logic [DEPTH:0]   next_fill;

    assign push       = in_valid_i && in_ready_o;
    assign pop        = out_valid_o && out_ready_i;
    assign next_fill  = fill + (DEPTH+1)'(push) - (DEPTH+1)'(pop);
    assign out_data_o = slot[0];

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            fill        <= '0;
            in_ready_o  <= 1'b1;
            out_valid_o <= 1'b0;
        end
        else
        begin
            fill        <= next_fill;
            in_ready_o  <= next_fill != (DEPTH+1)'(DEPTH);
            out_valid_o <= next_fill != '0;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            if (push && (int'(pop ? fill - 1'b1 : fill) == i))
                slot[i] <= in_data_i;
            else if (pop && i < DEPTH-1)
                slot[i] <= slot[i+1];
        end
    end
endmodule : cbwd_fifo

// ----------------------------------------------------------------------
// Top level.
// ----------------------------------------------------------------------
module cbwd_top
    import cbwd_pkg::*;
(
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_i,
    // AXI4-Lite register slave.
    input  wire logic [CBWD_ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic                   s_axi_awvalid_i,
    output logic                        s_axi_awready_o,
    input  wire logic [31:0]            s_axi_wdata_i,
    input  wire logic [3:0]             s_axi_wstrb_i,
    input  wire logic                   s_axi_wvalid_i,
    output logic                        s_axi_wready_o,
    output logic [1:0]                  s_axi_bresp_o,
    output logic                        s_axi_bvalid_o,
    input  wire logic                   s_axi_bready_i,
    input  wire logic [CBWD_ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic                   s_axi_arvalid_i,
    output logic                        s_axi_arready_o,
    output logic [31:0]                 s_axi_rdata_o,
    output logic [1:0]                  s_axi_rresp_o,
    output logic                        s_axi_rvalid_o,
    input  wire logic                   s_axi_rready_i,
    // Address decode requests.
    input  wire logic                   dec_valid_i,
    output logic                        dec_ready_o,
    input  wire logic [31:0]            dec_addr_i,
    input  wire logic                   dec_is_io_i,
    input  wire logic                   dec_from_card_i,
    // Decode results: {fwd, hit, window, is_io, prefetchable}.
    output logic                        res_valid_o,
    input  wire logic                   res_ready_i,
    output logic [CBWD_RES_W-1:0]       res_data_o,
    // CardBus initiator side; tick is one pulse per CardBus clock.
    input  wire logic                   cb_tick_i,
    input  wire logic                   cb_frame_start_i,
    input  wire logic                   cb_data_done_i,
    input  wire logic                   cb_txn_end_i,
    output logic                        cb_terminate_o
);

    // ------------------------------------------------------------------
    // Register storage.
    // ------------------------------------------------------------------
    logic [31:0] mem_lo [2];
    logic [31:0] mem_hi [2];
    logic [31:0] io_lo  [2];
    logic [31:0] io_hi  [2];
    logic [7:0]  lat_value;
    logic [7:0]  irq_line;
    logic [1:0]  window_prefetchable;
    logic [7:0]  lat_count;
    logic        lat_active;
    logic        lat_expired;

    // ------------------------------------------------------------------
    // AXI4-Lite write path.
    // ------------------------------------------------------------------
    logic [CBWD_ADDR_W-1:0] aw_addr;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   aw_have;
    logic                   w_have;
    logic                   do_write;
    logic [7:0]             w_idx;
    logic                   w_map;

    assign do_write = aw_have && w_have && !s_axi_bvalid_o;
    assign w_idx    = aw_addr[9:2];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [31:0] wmask);
        logic [31:0] be;
        be = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = (old & ~(be & wmask)) | (data & be & wmask);
    endfunction : merge

    function automatic logic mapped(input logic [CBWD_ADDR_W-1:0] a);
        logic [7:0] i;
        i = a[9:2];
        mapped = (a[CBWD_ADDR_W-1:10] == '0) && (a[1:0] == 2'b00) &&
                 (i == CBWD_IDX_LAT_COUNT || i == CBWD_IDX_MEM0_LO || i == CBWD_IDX_MEM0_HI ||
                  i == CBWD_IDX_MEM1_LO || i == CBWD_IDX_MEM1_HI || i == CBWD_IDX_IO0_LO ||
                  i == CBWD_IDX_IO0_HI || i == CBWD_IDX_IO1_LO || i == CBWD_IDX_IO1_HI ||
                  i == CBWD_IDX_IRQ_LINE || i == CBWD_IDX_BRIDGE || i == CBWD_IDX_LAT_STAT);
    endfunction : mapped

    assign w_map = mapped(aw_addr);

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            aw_have         <= 1'b0;
            w_have          <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= CBWD_RESP_OKAY;
            aw_addr         <= '0;
            w_data          <= '0;
            w_strb          <= '0;
        end
        else
        begin
            if (s_axi_awvalid_i && s_axi_awready_o)
            begin
                aw_addr         <= s_axi_awaddr_i;
                aw_have         <= 1'b1;
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o)
            begin
                w_data         <= s_axi_wdata_i;
                w_strb         <= s_axi_wstrb_i;
                w_have         <= 1'b1;
                s_axi_wready_o <= 1'b0;
            end
            if (do_write)
            begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= w_map ? CBWD_RESP_OKAY : CBWD_RESP_SLVERR;
            end
            if (s_axi_bvalid_o && s_axi_bready_i)
            begin
                s_axi_bvalid_o  <= 1'b0;
                aw_have         <= 1'b0;
                w_have          <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o  <= 1'b1;
            end
        end
    end

    // Only writable positions are touched, so read-only bits keep zero.
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            for (int k = 0; k < 2; k++)
            begin
                mem_lo[k] <= CBWD_WIN_RESET;
                mem_hi[k] <= CBWD_WIN_RESET;
                io_lo[k]  <= CBWD_WIN_RESET;
                io_hi[k]  <= CBWD_WIN_RESET;
            end
            lat_value           <= CBWD_LAT_RESET;
            irq_line            <= CBWD_IRQ_RESET;
            window_prefetchable <= CBWD_PF_RESET;
        end
        else if (do_write && w_map)
        begin
            case (w_idx)
                CBWD_IDX_LAT_COUNT: if (w_strb[0]) lat_value <= w_data[7:0];
                CBWD_IDX_MEM0_LO:   mem_lo[0] <= merge(mem_lo[0], w_data, w_strb, CBWD_MEM_WMASK);
                CBWD_IDX_MEM0_HI:   mem_hi[0] <= merge(mem_hi[0], w_data, w_strb, CBWD_MEM_WMASK);
                CBWD_IDX_MEM1_LO:   mem_lo[1] <= merge(mem_lo[1], w_data, w_strb, CBWD_MEM_WMASK);
                CBWD_IDX_MEM1_HI:   mem_hi[1] <= merge(mem_hi[1], w_data, w_strb, CBWD_MEM_WMASK);
                CBWD_IDX_IO0_LO:    io_lo[0]  <= merge(io_lo[0], w_data, w_strb, CBWD_IO_WMASK);
                CBWD_IDX_IO0_HI:    io_hi[0]  <= merge(io_hi[0], w_data, w_strb, CBWD_IO_WMASK);
                CBWD_IDX_IO1_LO:    io_lo[1]  <= merge(io_lo[1], w_data, w_strb, CBWD_IO_WMASK);
                CBWD_IDX_IO1_HI:    io_hi[1]  <= merge(io_hi[1], w_data, w_strb, CBWD_IO_WMASK);
                CBWD_IDX_IRQ_LINE:  if (w_strb[0]) irq_line <= w_data[7:0];
                CBWD_IDX_BRIDGE:
                begin
                    if (w_strb[1])
                        window_prefetchable <= w_data[CBWD_PF1_BIT:CBWD_PF0_BIT];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read path.
    // ------------------------------------------------------------------
    function automatic logic [31:0] read_word(input logic [7:0] i);
        case (i)
            CBWD_IDX_LAT_COUNT: read_word = {24'h0, lat_value};
            CBWD_IDX_MEM0_LO:   read_word = mem_lo[0];
            CBWD_IDX_MEM0_HI:   read_word = mem_hi[0];
            CBWD_IDX_MEM1_LO:   read_word = mem_lo[1];
            CBWD_IDX_MEM1_HI:   read_word = mem_hi[1];
            CBWD_IDX_IO0_LO:    read_word = io_lo[0];
            CBWD_IDX_IO0_HI:    read_word = io_hi[0];
            CBWD_IDX_IO1_LO:    read_word = io_lo[1];
            CBWD_IDX_IO1_HI:    read_word = io_hi[1];
            CBWD_IDX_IRQ_LINE:  read_word = {24'h0, irq_line};
            CBWD_IDX_BRIDGE:    read_word = {22'h0, window_prefetchable, 8'h0};
            CBWD_IDX_LAT_STAT:  read_word = {22'h0, lat_expired, lat_active, lat_count};
            default:            read_word = 32'h0;
        endcase
    endfunction : read_word

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= '0;
            s_axi_rresp_o   <= CBWD_RESP_OKAY;
        end
        else if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rdata_o   <= mapped(s_axi_araddr_i) ? read_word(s_axi_araddr_i[9:2]) : 32'h0;
            s_axi_rresp_o   <= mapped(s_axi_araddr_i) ? CBWD_RESP_OKAY : CBWD_RESP_SLVERR;
        end
        else if (s_axi_rvalid_o && s_axi_rready_i)
        begin
            s_axi_rvalid_o  <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Window decode.
    // ------------------------------------------------------------------
    logic [1:0]            mem_hit;
    logic [1:0]            io_hit;
    logic                  any_hit;
    logic                  hit_win;
    logic                  hit_pf;
    logic [CBWD_RES_W-1:0] next_res;

    always_comb
    begin
        for (int k = 0; k < 2; k++)
        begin
            mem_hit[k] = ((mem_lo[k] | mem_hi[k]) != '0) &&
                         dec_addr_i >= mem_lo[k] &&
                         dec_addr_i <= (mem_hi[k] | CBWD_MEM_LOW_ONES);
            io_hit[k]  = ((io_lo[k] | io_hi[k]) != '0) &&
                         (dec_addr_i & CBWD_IO_PAGE_MASK) == (io_lo[k] & CBWD_IO_PAGE_MASK) &&
                         dec_addr_i >= io_lo[k] &&
                         dec_addr_i <= (io_hi[k] | CBWD_IO_LOW_ONES);
        end
        any_hit = dec_is_io_i ? |io_hit : |mem_hit;
        hit_win = dec_is_io_i ? (!io_hit[0] && io_hit[1]) : (!mem_hit[0] && mem_hit[1]);
        hit_pf  = !dec_is_io_i && any_hit && window_prefetchable[hit_win];
        // Host cycles cross when they hit; card cycles cross upstream when they miss.
        next_res = {any_hit ^ dec_from_card_i, any_hit, hit_win, dec_is_io_i, hit_pf};
    end

    cbwd_fifo #(
        .WIDTH (CBWD_RES_W),
        .DEPTH (CBWD_BUF_DEPTH)
    ) u_res_buf (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .in_valid_i  (dec_valid_i),
        .in_ready_o  (dec_ready_o),
        .in_data_i   (next_res),
        .out_valid_o (res_valid_o),
        .out_ready_i (res_ready_i),
        .out_data_o  (res_data_o)
    );

    // ------------------------------------------------------------------
    // Secondary_latency_count. Small settings expire quickly, which is why
    // software should keep it at 20h or above.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            lat_count      <= '0;
            lat_active     <= 1'b0;
            lat_expired    <= 1'b0;
            cb_terminate_o <= 1'b0;
        end
        else
        begin
            cb_terminate_o <= 1'b0;
            if (cb_frame_start_i)
            begin
                lat_count   <= lat_value;
                lat_active  <= 1'b1;
                lat_expired <= lat_value == 8'h00;
            end
            else if (lat_active && cb_txn_end_i)
            begin
                lat_active  <= 1'b0;
                lat_expired <= 1'b0;
            end
            else if (lat_active && lat_expired && cb_data_done_i)
            begin
                cb_terminate_o <= 1'b1;
                lat_active     <= 1'b0;
                lat_expired    <= 1'b0;
            end
            else if (lat_active && cb_tick_i && lat_count != 8'h00)
            begin
                lat_count <= lat_count - 8'h01;
                if (lat_count == 8'h01)
                    lat_expired <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    default clocking cb_chk @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence s_expired_idle;
        lat_active && lat_expired && !cb_frame_start_i && !cb_txn_end_i;
    endsequence
    sequence s_phase_done;
        cb_data_done_i;
    endsequence

    a_stop_on_phase: assert property ((s_expired_idle and s_phase_done) |=> cb_terminate_o)
        else $error("terminate missing after expiry");
    a_stop_needs_expiry: assert property (cb_terminate_o |-> $past(lat_expired))
        else $error("terminate without expiry");
    a_count_load: assert property (cb_frame_start_i |=> lat_active && lat_count == $past(lat_value))
        else $error("latency count not loaded");
    a_mem_low_zero: assert property (mem_lo[0][11:0] == '0 && mem_hi[1][11:0] == '0)
        else $error("memory low bits not zero");
    a_io_ro_zero: assert property (io_lo[0][31:16] == '0 && io_hi[1][1:0] == '0)
        else $error("io read-only bits set");
    a_mem_zero_miss: assert property (!dec_is_io_i && mem_lo[0] == '0 && mem_hi[0] == '0 &&
                                      mem_lo[1] == '0 && mem_hi[1] == '0 |-> !any_hit)
        else $error("disabled memory window hit");
    a_io_zero_miss: assert property (dec_is_io_i && io_lo[0] == '0 && io_hi[0] == '0 &&
                                     io_lo[1] == '0 && io_hi[1] == '0 |-> !any_hit)
        else $error("disabled io window hit");
    a_res_ordered: assert property (dec_valid_i && dec_ready_o && !res_valid_o |=> res_valid_o &&
                                    res_data_o == $past(next_res))
        else $error("decode result lost");
    a_pf_follows: assert property ($rose(res_valid_o) && res_data_o[3] && !res_data_o[1] |->
                                   res_data_o[0] == (res_data_o[2] ? $past(window_prefetchable[1]) :
                                                     $past(window_prefetchable[0])))
        else $error("prefetch flag mismatch");

endmodule : cbwd_top

`default_nettype wire

// file: tb/cbwd_card_model.sv
`timescale 1ns/100ps
`default_nettype none
module cbwd_card_model
(
    input  wire logic       clk_sys_i,
    input  wire logic       stall_i,
    input  wire logic       res_valid_i,
    input  wire logic [4:0] res_data_i,
    output logic            res_ready_o,
    output logic [4:0]      got_o,
    output logic [7:0]      got_n_o,
    input  wire logic       term_i,
    output logic [7:0]      term_n_o,
    output logic            tick_o,
    output logic            frame_o,
    output logic            done_o,
    output logic            end_o
);
    assign res_ready_o = !stall_i;
    // Strobes stay low between frames, since the card clock tick does not run free.
    initial
    begin
        {got_o, got_n_o, term_n_o, tick_o, frame_o, done_o, end_o} = '0;
    end
    always @(posedge clk_sys_i)
    begin
        if (res_valid_i && res_ready_o)
        begin
            got_o   <= res_data_i;
            got_n_o <= got_n_o + 8'h01;
        end
        if (term_i)
            term_n_o <= term_n_o + 8'h01;
    end
    task automatic txn(input int nt);
        @(posedge clk_sys_i) frame_o <= 1'b1;
        @(posedge clk_sys_i) frame_o <= 1'b0;
        repeat (nt)
        begin
            @(posedge clk_sys_i) tick_o <= 1'b1;
            @(posedge clk_sys_i) tick_o <= 1'b0;
        end
        @(posedge clk_sys_i) done_o <= 1'b1;
        @(posedge clk_sys_i) done_o <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        end_o <= 1'b1;
        @(posedge clk_sys_i) end_o <= 1'b0;
    endtask : txn
endmodule : cbwd_card_model
`default_nettype wire

// file: tb/test_cbwd_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module test_cbwd_top
    import cbwd_pkg::*;
();
    logic        clk = 1'b0, rst;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, dec_addr;
    logic        awvalid, wvalid, bready, arvalid, rready, dec_valid, dec_io, dec_card, stall;
    logic        awready, wready, bvalid, arready, rvalid, dec_ready, res_valid, res_ready;
    logic        term, tick, frame, done, tend;
    logic [31:0] rdata;
    logic [1:0]  bresp, rresp;
    logic [4:0]  res_data, got;
    logic [7:0]  got_n, term_n, n, t;
    int          error_cnt = 0, n_tests = 0;
    logic [11:0] ra [6] = '{12'h06c, 12'h070, 12'h0a0, 12'h0b0, 12'h0f0, 12'h0f8};
    logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h000000ff, 32'h00000300};
    always #10 clk = ~clk;
    cbwd_top uut (.clk_sys_i(clk), .rst_i(rst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .dec_valid_i(dec_valid),
        .dec_ready_o(dec_ready), .dec_addr_i(dec_addr), .dec_is_io_i(dec_io), .dec_from_card_i(dec_card),
        .res_valid_o(res_valid), .res_ready_i(res_ready), .res_data_o(res_data), .cb_tick_i(tick),
        .cb_frame_start_i(frame), .cb_data_done_i(done), .cb_txn_end_i(tend), .cb_terminate_o(term));
    cbwd_card_model card (.clk_sys_i(clk), .stall_i(stall), .res_valid_i(res_valid), .res_data_i(res_data),
        .res_ready_o(res_ready), .got_o(got), .got_n_o(got_n), .term_i(term), .term_n_o(term_n),
        .tick_o(tick), .frame_o(frame), .done_o(done), .end_o(tend));
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    task automatic tmo();
        error_cnt++;
        end_sim();
    endtask : tmo
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = CBWD_RESP_OKAY);
        int i;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (i = 0; i < 100; i++)
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (i == 100) tmo();
        `CHK("bresp", er, bresp)
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = CBWD_RESP_OKAY);
        int i;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (i = 0; i < 100; i++)
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (i == 100) tmo();
        `CHK($sformatf("rdata %h", a), e, rdata)
        `CHK("rresp", er, rresp)
    endtask : rd
    task automatic dsend(input logic [31:0] a, input logic io, input logic cd);
        int i;
        @(posedge clk);
        dec_addr  <= a;
        dec_io    <= io;
        dec_card  <= cd;
        dec_valid <= 1'b1;
        for (i = 0; i < 100; i++)
        begin
            @(posedge clk);
            if (dec_ready) break;
        end
        dec_valid <= 1'b0;
        if (i == 100) tmo();
    endtask : dsend
    task automatic wait_n(input logic [7:0] c);
        for (int i = 0; i < 50 && got_n !== c; i++) @(posedge clk);
        if (got_n !== c) tmo();
    endtask : wait_n
    task automatic dchk(input logic [31:0] a, input logic io, cd, input logic [4:0] e, m);
        logic [7:0] c;
        c = got_n + 8'h01;
        dsend(a, io, cd);
        wait_n(c);
        `CHK($sformatf("decode %h", a), e, got & m)
    endtask : dchk
    initial
    begin
        {awaddr, araddr, wdata, dec_addr, awvalid, wvalid, bready, arvalid, rready} = '0;
        {dec_valid, dec_io, dec_card, stall} = '0;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 6; k++) rd(ra[k], rv[k]);
        dchk(32'h0, 1'b0, 1'b0, 5'h00, 5'h18);
        dchk(32'h0, 1'b1, 1'b0, 5'h00, 5'h18);
        wr(12'h070, '1);
        rd(12'h070, 32'hfffff000);
        wr(12'h0b0, '1);
        rd(12'h0b0, 32'h0000fffc);
        wr(12'h0c0, '1);
        rd(12'h0c0, 32'h0000fffc);
        wr(12'h0b0, 32'h0);
        wr(12'h0c0, 32'h0);
        wr(12'h200, 32'h1, CBWD_RESP_SLVERR);
        rd(12'h200, 32'h0, CBWD_RESP_SLVERR);
        wr(12'h070, 32'h10000000);
        wr(12'h080, 32'h10001000);
        dchk(32'h10001fff, 1'b0, 1'b0, 5'h19, 5'h1f);
        dchk(32'h10002000, 1'b0, 1'b0, 5'h00, 5'h18);
        dchk(32'h10000000, 1'b0, 1'b1, 5'h09, 5'h1f);
        dchk(32'h0fffffff, 1'b0, 1'b1, 5'h10, 5'h18);
        wr(12'h0f8, 32'h00000100);
        rd(12'h0f8, 32'h00000100);
        wr(12'h090, 32'h20000000);
        wr(12'h0a0, 32'h20000000);
        dchk(32'h20000fff, 1'b0, 1'b0, 5'h1c, 5'h1f);
        wr(12'h0d0, 32'h1000);
        wr(12'h0e0, 32'h1004);
        dchk(32'h1007, 1'b1, 1'b0, 5'h1e, 5'h1e);
        dchk(32'h1008, 1'b1, 1'b0, 5'h00, 5'h18);
        dchk(32'h1000, 1'b1, 1'b1, 5'h0e, 5'h1e);
        stall <= 1'b1;
        n = got_n;
        dsend(32'h10000000, 1'b0, 1'b0);
        dsend(32'h20000000, 1'b0, 1'b0);
        @(posedge clk);
        `CHK("dec_ready", 1'b0, dec_ready)
        stall <= 1'b0;
        wait_n(n + 8'h02);
        `CHK("second result", 5'h1c, got)
        wr(12'h06c, 32'h2);
        rd(12'h06c, 32'h2);
        t = term_n;
        card.txn(1);
        `CHK("early stop", t, term_n)
        card.txn(2);
        `CHK("stop", t + 8'h01, term_n)
        wr(12'h06c, 32'h0);
        card.txn(0);
        `CHK("stop at zero", t + 8'h02, term_n)
        wr(12'h06c, 32'h20);
        card.txn(3);
        `CHK("no stop at 20h", t + 8'h02, term_n)
        wr(12'h0f0, 32'h5a);
        rd(12'h0f0, 32'h5a);
        end_sim();
    end
endmodule : test_cbwd_top
`default_nettype wire
